// ===== logic/cmx_mem_index.sv
// Core memory cycle timing, buffer and transfer words, address indexing.
// Assumes phases, run state and the program counter come from outside,
// and that the memory stack answers on the sense lines by T2.
// Summary of operation
// - Index tag adds low index bits
// - Index register recirculates unless blocked
// - Memory read starts at T7
// - Memory write spans T24 to T11
// - Address register cleared T10, loaded T9
// - T8 clears buffer, starts cycle
// - Start sets gate when power enabled
// - Read timing T7 through T0 gated
// - T2 strobe loads buffer from sense
// - Copy to transfer regenerates buffer
// - Final-time clear arms pending store
// - Write timing T18 to T12, overlapping
// - Digit timing T21 through T12 gated
// - Direction outputs reverse core current
// - Serial full adder, inverted sum
// - Phase zero shifts transfer through adder
// - Index flag selects index as augend
// - Add T23 to T10, branches feed counter
// - T9 copies rotated address to selection
// - T24 loads code unless indirect/operator
// - Indirect bit sets flag, holds phase
// - Indirect flag clears on plain word
module cmx_mem_index (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_go,
   input wire logic [2:0] i_phase,
   input wire logic i_shift_op,
   input wire logic i_ts_second,
   input wire logic i_mem_power_enable,
   input wire logic i_store_new,
   input wire logic i_copy_to_xfer,
   input wire logic i_xfer_wr,
   input wire logic [cmx_pkg::W_WORD-1:0] i_xfer_data,
   input wire logic i_sel_pc,
   input wire logic [cmx_pkg::W_ADDR-1:0] i_pc,
   input wire logic [cmx_pkg::W_MBUF-1:0] i_sense_data,
   input wire logic i_norm_step,
   input wire logic i_index_new_bit,
   output cmx_pkg::cmx_mem_ctl_s o_mem_ctl,
   output logic [cmx_pkg::W_ADDR-1:0] o_mem_addr,
   output logic [cmx_pkg::W_MBUF-1:0] o_mem_buf,
   output logic [cmx_pkg::W_WORD-1:0] o_xfer,
   output logic [cmx_pkg::W_OP-1:0] o_op_code,
   output logic [cmx_pkg::W_PT-1:0] o_pulse_time,
   output logic o_index_active,
   output logic o_indirect,
   output logic o_phase_hold,
   output logic o_pending_store,
   output logic o_pc_bit,
   output logic o_pc_shift
);
   import cmx_pkg::*;

   cmx_state_s st;
   cmx_state_s next_st;
   logic x_now;
   logic x_block;
   logic ph0;
   logic skip;
   logic cyc_start;
   logic shift;
   logic add_win;
   logic branch;
   logic xz;
   logic yz;
   logic nsum;
   logic sum;
   logic carry;
   logic [W_ADDR-1:0] c_addr;

   // ************************************************************
   // Pulse time windows
   // ************************************************************
   function automatic logic in_win(input logic [4:0] pt,
                                   input logic [4:0] lo,
                                   input logic [4:0] hi);
      in_win = (pt >= lo) && (pt <= hi);
   endfunction

   // Q2 high marks the write half of the memory cycle
   function automatic logic q2_of(input logic [4:0] pt);
      q2_of = in_win(pt, PT_T11, PT_T24);
   endfunction

   // ************************************************************
   // Index register
   // ************************************************************
   // recirculation block terms
   assign x_block = (st.op == OP_LOAD_INDEX && i_phase == PH_SIX)
      || (ph0 && st.op == OP_INC_BRANCH && st.ia)
      || (i_phase == PH_THREE && st.op == OP_NORMALIZE && i_norm_step)
      || (ph0 && st.op == OP_COPY_EA && !st.ia && q2_of(st.pt));

   cmx_index_reg #(
      .LEN(IDX_DELAY)
   ) cmx_index_reg_inst (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_block(x_block),
      .i_new_bit(i_index_new_bit),
      .o_now(x_now)
   );

   // ************************************************************
   // Decodes shared by the next-state logic
   // ************************************************************
   assign ph0 = (i_phase == PH_ZERO);
   // no cycle in shift phases one/three or interlace second
   assign skip = (i_shift_op && (i_phase == PH_ONE || i_phase == PH_THREE))
      || i_ts_second;
   assign cyc_start = (st.pt == PT_T8) && !skip;
   assign shift = ph0 && i_go && st.pt != PT_FINAL && st.pt != PT_T24;
   assign add_win = in_win(st.pt, PT_T10, PT_T23);
   assign branch = !st.ia && (st.op == OP_BRANCH || st.op == OP_INC_BRANCH
      || st.op == OP_BRANCH_MARK);

   // index only as augend when flagged, else zero
   assign xz = st.ix & x_now;
   // addend is the transfer word lsb
   assign yz = st.c[W_WORD-1];
   // inverted sum formed, true sum by negation
   assign nsum = ~(xz ^ yz ^ st.cz);
   assign sum = ~nsum;
   assign carry = (xz & yz) | (xz & st.cz) | (yz & st.cz);

   // after fourteen shifts the address sits in bits 0 to 13
   always_comb begin
      c_addr = '0;
      for (int i = 0; i < W_ADDR; i++) begin
         c_addr[W_ADDR-1-i] = st.c[i];
      end
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_st = st;

      if (st.pt == PT_FINAL) begin
         next_st.pt = PT_T24;
      end else if (st.pt == PT_T0) begin
         next_st.pt = PT_FINAL;
      end else begin
         next_st.pt = st.pt - 1'b1;
      end

      if (st.pt == PT_T10) begin
         next_st.s = '0;
      end else if (st.pt == PT_T9) begin
         // phase zero copy suppressed while a store is pending
         if (ph0) begin
            if (!st.pend) begin
               next_st.s = c_addr;
            end
         end else if (i_sel_pc) begin
            next_st.s = i_pc;
         end else begin
            next_st.s = st.c[W_ADDR-1:0];
         end
      end

      if (cyc_start) begin
         next_st.m = '0;
      end
      if (st.pt == PT_T2 && st.gate) begin
         next_st.m = i_sense_data;
      end
      // store clears buffer and arms the pending flag
      if (st.pt == PT_FINAL && i_store_new) begin
         next_st.m = '0;
         next_st.pend = 1'b1;
      end
      if (st.pt == PT_T24 && st.pend) begin
         next_st.m = {1'b0, st.c};
         next_st.pend = 1'b0;
      end

      // gate set on start, cleared at T11
      if (cyc_start && i_mem_power_enable) begin
         next_st.gate = 1'b1;
      end else if (st.pt == PT_T11) begin
         next_st.gate = 1'b0;
      end

      // buffer untouched, so it is written back
      if (st.pt == PT_FINAL && i_copy_to_xfer) begin
         next_st.c = st.m[W_WORD-1:0];
      end else if (i_xfer_wr) begin
         next_st.c = i_xfer_data;
      end

      next_st.pc_shift = 1'b0;
      next_st.pc_bit = 1'b0;
      if (shift) begin
         // branches keep the address and index into the counter
         if (add_win && !branch) begin
            next_st.c = {st.c[W_WORD-2:0], sum};
         end else begin
            next_st.c = {st.c[W_WORD-2:0], yz};
         end
         if (add_win) begin
            next_st.cz = carry;
            next_st.pc_shift = branch;
            next_st.pc_bit = branch & sum;
         end
      end
      if (ph0 && !st.ix) begin
         next_st.cz = 1'b0;
      end

      if (ph0 && i_go && st.pt == PT_T24) begin
         next_st.cz = 1'b0;
         // index flag from the tag bit
         if (st.c[C_INDEX_BIT]) begin
            next_st.ix = 1'b1;
         end
         // code copy unless indirect or program operator
         if (!st.ia && !st.c[C_PROG_OP_BIT]) begin
            for (int i = 0; i < W_OP; i++) begin
               next_st.op[W_OP-1-i] = st.c[C_OP_MSB+i];
            end
         end
         if (!st.ia && !st.c[C_PROG_OP_BIT] && st.c[C_INDIRECT_BIT]) begin
            next_st.ia = 1'b1;
         // clear only on a word without the indirect bit
         end else if (st.ia && !st.c[C_INDIRECT_BIT]) begin
            next_st.ia = 1'b0;
         end
      end
      // index flag ends with the phase
      if (st.pt == PT_FINAL) begin
         next_st.ix = 1'b0;
      end

      // Memory timing, decoded from the next state so outputs are flops
      next_st.ctl.start = cyc_start;
      next_st.ctl.read_timing = next_st.gate
         && in_win(next_st.pt, PT_T0, PT_T7);
      next_st.ctl.digit_timing = next_st.gate
         && in_win(next_st.pt, PT_T12, PT_T21);
      // two overlapping terms avoid a crossover spike
      next_st.ctl.write_timing = next_st.gate
         && (in_win(next_st.pt, PT_T12, PT_T15)
         || in_win(next_st.pt, PT_T14, PT_T18));
      next_st.ctl.read_dir = next_st.gate && !q2_of(next_st.pt);
      next_st.ctl.write_dir = next_st.gate && q2_of(next_st.pt)
         && (next_st.ctl.digit_timing || next_st.pt[0]);
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
         st.pt <= PT_T24;
      end else begin
         st <= next_st;
      end
   end

   // All outputs are fields of the state register
   assign o_mem_ctl = st.ctl;
   assign o_mem_addr = st.s;
   assign o_mem_buf = st.m;
   assign o_xfer = st.c;
   assign o_op_code = st.op;
   assign o_pulse_time = st.pt;
   assign o_index_active = st.ix;
   assign o_indirect = st.ia;
   assign o_phase_hold = st.ia;
   assign o_pending_store = st.pend;
   assign o_pc_bit = st.pc_bit;
   assign o_pc_shift = st.pc_shift;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   AST_PT_WRAP: assert property (st.pt == PT_FINAL |=> st.pt == PT_T24)
      else $error("final pulse not followed by T24");
   AST_GATE_SET: assert property (cyc_start && i_mem_power_enable
      |=> st.gate && o_mem_ctl.start)
      else $error("gate not set by cycle start");
   AST_GATE_CLR: assert property (st.pt == PT_T11 |=> !st.gate)
      else $error("gate not cleared after T11");
   AST_READ_WIN: assert property (o_mem_ctl.read_timing
      == (st.gate && st.pt <= PT_T7))
      else $error("read timing outside T7 to T0");
   AST_STROBE: assert property (st.pt == PT_T2 && st.gate && !i_store_new
      |=> st.m == $past(i_sense_data))
      else $error("buffer not loaded at strobe");
   AST_PEND_COPY: assert property (st.pend && st.pt == PT_T24
      |=> !st.pend && st.m == {1'b0, $past(st.c)})
      else $error("pending store not completed");
   AST_WRITE_IN_DIGIT: assert property (o_mem_ctl.write_timing
      |-> o_mem_ctl.digit_timing)
      else $error("write timing outside digit window");
   AST_SEL_CLEAR: assert property (st.pt == PT_T10 |=> st.s == '0)
      else $error("selection register not cleared");
   AST_DIR_EXCL: assert property (!(o_mem_ctl.read_dir
      && o_mem_ctl.write_dir))
      else $error("both current directions on");
   AST_HOLD: assert property (ph0 && i_go && st.pt == PT_T24 && !st.ia
      && !st.c[C_PROG_OP_BIT] && st.c[C_INDIRECT_BIT]
      |=> o_phase_hold && st.ia)
      else $error("indirect bit did not hold the phase");

   COV_INDIRECT: cover property (!st.ia ##1 st.ia);
   COV_STORE: cover property (st.pend ##1 !st.pend);
   COV_INDEX: cover property (st.ix && add_win && x_now);
endmodule

// ===== pkg/cmx_pkg.sv
// Shared constants and carriers for the core memory cycle and indexing.
// Assumes one 20 MHz clock and an outside sequencer that supplies phases.
package cmx_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int W_ADDR = 14;
   localparam int W_WORD = 24;
   localparam int W_MBUF = 25;
   localparam int W_OP = 6;
   localparam int W_PT = 5;
   localparam int IDX_DELAY = 24;

   // ************************************************************
   // Pulse times, counted downward, final pulse after T0
   // ************************************************************
   localparam logic [4:0] PT_T24 = 5'h18;
   localparam logic [4:0] PT_T23 = 5'h17;
   localparam logic [4:0] PT_T21 = 5'h15;
   localparam logic [4:0] PT_T18 = 5'h12;
   localparam logic [4:0] PT_T15 = 5'h0f;
   localparam logic [4:0] PT_T14 = 5'h0e;
   localparam logic [4:0] PT_T12 = 5'h0c;
   localparam logic [4:0] PT_T11 = 5'h0b;
   localparam logic [4:0] PT_T10 = 5'h0a;
   localparam logic [4:0] PT_T9 = 5'h09;
   localparam logic [4:0] PT_T8 = 5'h08;
   localparam logic [4:0] PT_T7 = 5'h07;
   localparam logic [4:0] PT_T2 = 5'h02;
   localparam logic [4:0] PT_T0 = 5'h00;
   localparam logic [4:0] PT_FINAL = 5'h19;

   // ************************************************************
   // Instruction word fields (bit 0 is the sign, bit 23 the lsb)
   // ************************************************************
   localparam int C_INDEX_BIT = 1;
   localparam int C_PROG_OP_BIT = 2;
   localparam int C_OP_MSB = 3;
   localparam int C_INDIRECT_BIT = 9;

   // Operation codes
   localparam logic [5:0] OP_BRANCH = 6'h01;
   localparam logic [5:0] OP_INC_BRANCH = 6'h21;
   localparam logic [5:0] OP_BRANCH_MARK = 6'h23;
   localparam logic [5:0] OP_NORMALIZE = 6'h37;
   localparam logic [5:0] OP_LOAD_INDEX = 6'h39;
   localparam logic [5:0] OP_COPY_EA = 6'h3f;

   // Phases
   localparam logic [2:0] PH_ZERO = 3'h0;
   localparam logic [2:0] PH_ONE = 3'h1;
   localparam logic [2:0] PH_THREE = 3'h3;
   localparam logic [2:0] PH_SIX = 3'h6;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic start;
      logic read_timing;
      logic write_timing;
      logic digit_timing;
      logic read_dir;
      logic write_dir;
   } cmx_mem_ctl_s;

   typedef struct packed {
      logic [W_PT-1:0] pt;
      logic gate;
      logic pend;
      logic cz;
      logic ix;
      logic ia;
      logic [W_MBUF-1:0] m;
      logic [W_WORD-1:0] c;
      logic [W_ADDR-1:0] s;
      logic [W_OP-1:0] op;
      cmx_mem_ctl_s ctl;
      logic pc_bit;
      logic pc_shift;
   } cmx_state_s;

endpackage

// ===== logic/cmx_index_reg.sv
// Recirculating index register: write stage, delay path, output stage.
// Assumes the caller blocks recirculation and supplies new bits itself.
module cmx_index_reg
   import cmx_pkg::*;
#(
   parameter int LEN = cmx_pkg::IDX_DELAY
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_block,
   input wire logic i_new_bit,
   output logic o_now
);
   import cmx_pkg::*;

   typedef struct packed {
      logic wr;
      logic [LEN-1:0] dly;
      logic now;
   } cmx_xreg_s;

   cmx_xreg_s st;
   cmx_xreg_s next_st;

   // ************************************************************
   // Recirculation path
   // ************************************************************
   // recirculation unless blocked, when the new bit is written instead
   always_comb begin
      next_st = st;
      next_st.wr = i_block ? i_new_bit : st.now;
      next_st.dly = {st.dly[LEN-2:0], st.wr};
      next_st.now = st.dly[LEN-1];
   end

   // Write and output stages are never disabled
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_now = st.now;

endmodule

// ===== verif/cmx_core_mem.sv
// Core memory stack model for the cycle timing and indexing block.
// Assumes address and buffer stay put while the timing levels stand.
module cmx_core_mem
   import cmx_pkg::*;
(
   input wire logic i_clk,
   input wire cmx_pkg::cmx_mem_ctl_s i_ctl,
   input wire logic [cmx_pkg::W_ADDR-1:0] i_addr,
   input wire logic [cmx_pkg::W_MBUF-1:0] i_buf,
   output logic [cmx_pkg::W_MBUF-1:0] o_sense
);
   timeunit 1ns;
   timeprecision 1ns;

   // ************************************************************
   // Core array
   // ************************************************************
   logic [W_MBUF-1:0] core [logic [W_ADDR-1:0]];
   logic [W_MBUF-1:0] word = '0;
   logic rd_q = 1'b0;

   // sense while reading
   // Released lines show the inverse, so a late strobe sees junk
   assign o_sense = i_ctl.read_timing ? word : ~word;

   // destructive read, write-back
   // Nothing survives a read unless the block writes it back
   always @(posedge i_clk) begin
      rd_q <= i_ctl.read_timing;
      if (i_ctl.read_timing && !rd_q) begin
         word <= core.exists(i_addr) ? core[i_addr] : '0;
         core[i_addr] = '0;
      end
      if (i_ctl.write_timing && i_ctl.digit_timing) begin
         core[i_addr] = i_buf;
      end
   end

   // Preload of a word by the bench
   task automatic put(input logic [W_ADDR-1:0] a,
                      input logic [W_MBUF-1:0] d);
      core[a] = d;
   endtask
endmodule

// ===== verif/cmx_mem_index_tb.sv
// Self-checking bench for the memory cycle and address indexing block.
// Assumes the core memory model drives the sense lines.
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("wrong value t=%0t got %0h exp %0h", $time, got, exp); \
      end \
   end

module cmx_mem_index_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import cmx_pkg::*;

   // Pulse time T1, the cycle after the strobe
   localparam logic [4:0] PT_T1 = 5'h01;
   localparam logic [13:0] IX = 14'h0155;
   localparam logic [13:0] A = 14'h0234;
   localparam logic [13:0] P = 14'h0123;
   localparam logic [13:0] B = 14'h0040;
   localparam logic [13:0] E = 14'h0100;
   localparam logic [24:0] D = 25'h1abcdef;
   localparam logic [23:0] V = 24'h5a5a5a;

   logic i_clk, i_rst_n, i_go, i_shift_op, i_ts_second;
   logic i_mem_power_enable, i_store_new, i_copy_to_xfer, i_xfer_wr;
   logic i_sel_pc, i_norm_step, i_index_new_bit;
   logic [2:0] i_phase;
   logic [23:0] i_xfer_data;
   logic [13:0] i_pc, o_mem_addr, pcv;
   logic [24:0] i_sense_data, o_mem_buf;
   cmx_mem_ctl_s o_mem_ctl, ectl;
   logic [23:0] o_xfer;
   logic [5:0] o_op_code;
   logic [4:0] o_pulse_time, ept;
   logic o_index_active, o_indirect, o_phase_hold, o_pending_store;
   logic o_pc_bit, o_pc_shift, strt, gok, g;
   logic [5:0] brs [3] = '{OP_BRANCH, OP_INC_BRANCH, OP_BRANCH_MARK};
   int failures = 0;
   int cmp_count = 0;
   int pcn = 0;

   cmx_mem_index cmx_mem_index_inst (
      .i_clk, .i_rst_n, .i_go, .i_phase, .i_shift_op, .i_ts_second,
      .i_mem_power_enable, .i_store_new, .i_copy_to_xfer, .i_xfer_wr,
      .i_xfer_data, .i_sel_pc, .i_pc, .i_sense_data, .i_norm_step,
      .i_index_new_bit, .o_mem_ctl, .o_mem_addr, .o_mem_buf, .o_xfer,
      .o_op_code, .o_pulse_time, .o_index_active, .o_indirect,
      .o_phase_hold, .o_pending_store, .o_pc_bit, .o_pc_shift
   );

   cmx_core_mem cmx_core_mem_inst (
      .i_clk(i_clk), .i_ctl(o_mem_ctl), .i_addr(o_mem_addr),
      .i_buf(o_mem_buf), .o_sense(i_sense_data)
   );

   // Clock, 50 ns period
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   // ************************************************************
   // Monitor: pulse time and memory timing every clock
   // ************************************************************
   // expected pulse time
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ept <= PT_T24;
      end else begin
         ept <= (ept == PT_T0) ? PT_FINAL :
                (ept == PT_FINAL) ? PT_T24 : ept - 5'h01;
      end
   end

   // Sampled mid-cycle so every registered output has settled
   always @(negedge i_clk) begin
      if (!i_rst_n) begin
         strt = 1'b0;
         gok = 1'b0;
      end else begin
         `CHK(o_pulse_time, ept)
         if (ept == PT_T10) gok = 1'b0;
         g = gok;
         ectl.start = (ept == PT_T7) && strt;
         ectl.read_timing = g && ept <= PT_T7;
         ectl.write_timing = g && ept <= PT_T18 && ept >= PT_T12;
         ectl.digit_timing = g && ept <= PT_T21 && ept >= PT_T12;
         ectl.read_dir = g && (ept <= PT_T10 || ept == PT_FINAL);
         ectl.write_dir = g && ept >= PT_T11 && ept <= PT_T24 &&
                          (ectl.digit_timing || ept[0]);
         `CHK(o_mem_ctl, ectl)
         if (ept == PT_T8) begin
            strt = !(i_shift_op && (i_phase == PH_ONE ||
                     i_phase == PH_THREE)) && !i_ts_second;
            gok = strt && i_mem_power_enable;
         end
         if (o_pc_shift === 1'b1) begin
            pcv = {o_pc_bit, pcv[13:1]};
            pcn++;
         end
      end
   end

   // ************************************************************
   // Access tasks
   // ************************************************************
   // Returns at the edge that opens pulse time p
   task automatic to_pt(input logic [4:0] p);
      logic [4:0] q;
      q = (p == PT_FINAL) ? PT_T0 : (p == PT_T24) ? PT_FINAL : p + 5'h01;
      @(posedge i_clk);
      while (o_pulse_time !== q) @(posedge i_clk);
   endtask

   task automatic look(input logic [4:0] p);
      to_pt(p);
      @(negedge i_clk);
   endtask

   task automatic ph(input logic [2:0] p);
      to_pt(PT_T24);
      i_phase <= p;
   endtask

   task automatic load_x(input logic [23:0] w);
      to_pt(PT_T2);
      i_xfer_wr <= 1'b1;
      i_xfer_data <= w;
      @(posedge i_clk);
      i_xfer_wr <= 1'b0;
   endtask

   function automatic logic [23:0] mkw(input logic ix, ind,
                                       input logic [5:0] op,
                                       input logic [13:0] a);
      logic [23:0] w;
      w = '0;
      w[C_INDEX_BIT] = ix;
      w[C_INDIRECT_BIT] = ind;
      for (int k = 0; k < 6; k++) w[C_OP_MSB + k] = op[5 - k];
      for (int k = 0; k < 14; k++) w[10 + k] = a[13 - k];
      return w;
   endfunction

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Hang guard, over ten times the length of the test sequence
   initial begin
      repeat (8000) @(posedge i_clk);
      failures++;
      print_verdict;
   end

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      i_rst_n = 1'b0;
      i_go = 1'b1;
      i_phase = 3'h2;
      {i_shift_op, i_ts_second, i_store_new, i_copy_to_xfer} = 4'h0;
      {i_xfer_wr, i_norm_step, i_index_new_bit} = 3'h0;
      i_mem_power_enable = 1'b1;
      i_sel_pc = 1'b1;
      i_pc = P;
      i_xfer_data = '0;
      cmx_core_mem_inst.put(P, D);
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      // Read, copy and regenerate
      look(PT_T8);
      `CHK(o_mem_addr, P)
      look(PT_T1);
      `CHK(o_mem_buf, D)
      to_pt(PT_FINAL);
      i_copy_to_xfer <= 1'b1;
      to_pt(PT_T23);
      i_copy_to_xfer <= 1'b0;
      @(negedge i_clk);
      `CHK(o_xfer, D[23:0])
      look(PT_T9);
      `CHK(o_mem_addr, 14'h0000)
      look(PT_T7);
      `CHK(o_mem_buf, 25'h0000000)
      look(PT_T1);
      `CHK(o_mem_buf, D)
      // Store of new data through the pending flag
      load_x(V);
      to_pt(PT_FINAL);
      i_store_new <= 1'b1;
      to_pt(PT_T24);
      i_store_new <= 1'b0;
      @(negedge i_clk);
      `CHK(o_pending_store, 1'b1)
      `CHK(o_mem_buf, 25'h0000000)
      look(PT_T23);
      `CHK(o_pending_store, 1'b0)
      look(PT_T1);
      `CHK(o_mem_buf, {1'b0, V})
      // Load the index register serially, lsb at T23
      load_x(mkw(1'b0, 1'b0, OP_LOAD_INDEX, 14'h0000));
      ph(PH_ZERO);
      ph(PH_SIX);
      for (int t = 23; t >= 10; t--) begin
         to_pt(t[4:0]);
         i_index_new_bit <= IX[23 - t];
      end
      to_pt(PT_T9);
      i_index_new_bit <= 1'b0;
      `CHK(o_op_code, OP_LOAD_INDEX)
      ph(3'h2);
      // Indexed operand address
      load_x(mkw(1'b1, 1'b0, 6'h2a, A));
      ph(PH_ZERO);
      look(PT_T23);
      `CHK(o_index_active, 1'b1)
      `CHK(o_op_code, 6'h2a)
      look(PT_T8);
      `CHK(o_mem_addr, A + IX)
      look(PT_FINAL);
      `CHK(o_xfer, mkw(1'b1, 1'b0, 6'h2a, A + IX))
      ph(3'h2);
      @(negedge i_clk);
      `CHK(o_index_active, 1'b0)
      // Branch codes index into the counter instead
      foreach (brs[i]) begin
         load_x(mkw(1'b1, 1'b0, brs[i], A));
         ph(PH_ZERO);
         pcn = 0;
         look(PT_FINAL);
         `CHK(o_xfer, mkw(1'b1, 1'b0, brs[i], A))
         `CHK(pcv, A + IX)
         `CHK(pcn, 14)
         ph(3'h2);
      end
      // Indirect chain of one level, indexed second word
      cmx_core_mem_inst.put(B, {1'b0, mkw(1'b1, 1'b0, 6'h33, E)});
      load_x(mkw(1'b0, 1'b1, 6'h15, B));
      ph(PH_ZERO);
      look(PT_T23);
      `CHK(o_indirect, 1'b1)
      `CHK(o_phase_hold, 1'b1)
      look(PT_T8);
      `CHK(o_mem_addr, B)
      to_pt(PT_FINAL);
      i_copy_to_xfer <= 1'b1;
      ph(PH_ZERO);
      i_copy_to_xfer <= 1'b0;
      look(PT_T23);
      `CHK(o_indirect, 1'b0)
      `CHK(o_op_code, 6'h15)
      look(PT_T8);
      `CHK(o_mem_addr, E + IX)
      // Refused starts and power off, checked by the monitor
      for (int k = 0; k < 4; k++) begin
         ph(k[0] ? PH_THREE : PH_ONE);
         i_shift_op <= (k < 2);
         i_ts_second <= (k == 2);
         i_mem_power_enable <= (k != 3);
      end
      ph(3'h2);
      {i_shift_op, i_ts_second} <= 2'h0;
      i_mem_power_enable <= 1'b1;
      look(PT_FINAL);
      look(PT_FINAL);
      print_verdict;
   end
endmodule
